/* logic/oame_pkg.sv */
package oame_pkg;

    localparam int DATA_WIDTH = 8;
    localparam int INSTR_WIDTH = 14;
    localparam int FILE_ADDR_WIDTH = 7;
    localparam int SPECIAL_ADDR_WIDTH = 6;

    // opcode field and its sub-fields
    localparam int OPCODE_MSB = 13;
    localparam int OPCODE_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int SPECIAL_SEL_MSB = 7;
    localparam int SPECIAL_SEL_LSB = 6;

    localparam logic [5:0] OPCODE_OR_LITERAL = 6'h1a;
    localparam logic [5:0] OPCODE_OR_FILE = 6'h04;
    localparam logic [5:0] OPCODE_COPY_FILE = 6'h08;
    localparam logic [5:0] OPCODE_LOAD_LITERAL = 6'h19;
    localparam logic [5:0] OPCODE_STORE = 6'h00;
    localparam logic [1:0] SPECIAL_SEL = 2'h0;
    localparam logic [INSTR_WIDTH-1:0] INSTR_NO_OPERATION = 14'h0000;

    localparam logic DEST_ACCUMULATOR = 1'h0;
    localparam logic DEST_FILE = 1'h1;

    localparam logic [DATA_WIDTH-1:0] ACCUMULATOR_RESET = 8'h00;
    localparam logic [DATA_WIDTH-1:0] DATA_ZERO = 8'h00;
    localparam logic ZERO_FLAG_RESET = 1'h0;

    typedef enum logic [2:0] {
        OAME_OP_NONE = 3'b000,
        OAME_OP_OR_LITERAL_INTO_ACCUMULATOR = 3'b001,
        OAME_OP_OR_ACCUMULATOR_WITH_FILE = 3'b010,
        OAME_OP_COPY_FILE_TO_ACCUMULATOR = 3'b011,
        OAME_OP_LOAD_LITERAL_TO_ACCUMULATOR = 3'b100,
        OAME_OP_STORE_ACCUMULATOR_TO_FILE = 3'b101,
        OAME_OP_STORE_ACCUMULATOR_TO_SPECIAL = 3'b110
    } oame_op_type;

    typedef struct packed {
        oame_op_type op;
        logic dest;
        logic [FILE_ADDR_WIDTH-1:0] file_addr;
        logic [SPECIAL_ADDR_WIDTH-1:0] special_addr;
        logic [DATA_WIDTH-1:0] literal;
    } oame_decoded_type;

    typedef struct packed {
        logic en;
        logic [FILE_ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } oame_file_write_type;

    typedef struct packed {
        logic en;
        logic [SPECIAL_ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } oame_special_write_type;

endpackage

/* logic/oame_decoder.sv */
`timescale 1ns/1ps
module oame_decoder
    import oame_pkg::*;
(
    input wire logic [INSTR_WIDTH-1:0] instr,
    output oame_decoded_type decoded
);

    logic [5:0] opcode;

    assign opcode = instr[OPCODE_MSB:OPCODE_LSB];

    always_comb
    begin
        decoded.op = OAME_OP_NONE;
        decoded.dest = instr[DEST_BIT];
        decoded.file_addr = instr[FILE_ADDR_WIDTH-1:0];
        decoded.special_addr = instr[SPECIAL_ADDR_WIDTH-1:0];
        decoded.literal = instr[DATA_WIDTH-1:0];
        case (opcode)
            OPCODE_OR_LITERAL:
            begin
                decoded.op = OAME_OP_OR_LITERAL_INTO_ACCUMULATOR;
            end
            OPCODE_OR_FILE:
            begin
                decoded.op = OAME_OP_OR_ACCUMULATOR_WITH_FILE;
            end
            OPCODE_COPY_FILE:
            begin
                // bit 7 set belongs to another instruction group
                if (instr[DEST_BIT] == DEST_ACCUMULATOR)
                begin
                    decoded.op = OAME_OP_COPY_FILE_TO_ACCUMULATOR;
                end
            end
            OPCODE_LOAD_LITERAL:
            begin
                decoded.op = OAME_OP_LOAD_LITERAL_TO_ACCUMULATOR;
            end
            OPCODE_STORE:
            begin
                if (instr[DEST_BIT])
                begin
                    decoded.op = OAME_OP_STORE_ACCUMULATOR_TO_FILE;
                end
                // all-zero word is the no-operation, not a store to special 0
                else if (instr[SPECIAL_SEL_MSB:SPECIAL_SEL_LSB] == SPECIAL_SEL && instr != INSTR_NO_OPERATION)
                begin
                    decoded.op = OAME_OP_STORE_ACCUMULATOR_TO_SPECIAL;
                end
            end
            default:
            begin
                decoded.op = OAME_OP_NONE;
            end
        endcase
    end

endmodule

/* logic/oame_exec.sv */
// Summary of operation
// - literal OR: accumulator ORed with 8-bit literal, zero flag updated, one cycle.
// - file OR: accumulator ORed with addressed file register, zero flag updated, one cycle.
// - file OR destination bit 0 writes accumulator, 1 writes the file register.
// - file address is a full 7-bit field up to 7Fh; destination is one bit.
// - copy file register to accumulator; no flag change; one cycle.
// - load 8-bit literal into accumulator; no flag change; one cycle.
// - store accumulator into addressed file register; accumulator and flags kept.
// - store accumulator into 6-bit addressed special register; accumulator and flags kept.
`timescale 1ns/1ps
module oame_exec
    import oame_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [INSTR_WIDTH-1:0] instr,
    input wire logic [DATA_WIDTH-1:0] file_rd_data,
    output logic [DATA_WIDTH-1:0] accumulator,
    output logic zero_flag,
    output oame_file_write_type file_write,
    output oame_special_write_type special_write,
    output logic instr_done
);

    oame_decoded_type decoded;
    logic is_or_literal;
    logic is_or_file;
    logic is_copy_file;
    logic is_load_literal;
    logic is_store_file;
    logic is_store_special;
    logic or_to_accumulator;
    logic or_to_file;
    logic [DATA_WIDTH-1:0] or_operand;
    logic [DATA_WIDTH-1:0] or_result;
    logic or_result_zero;
    logic [DATA_WIDTH-1:0] next_accumulator;
    logic next_zero_flag;
    oame_file_write_type next_file_write;
    oame_special_write_type next_special_write;
    logic next_instr_done;

    oame_decoder oame_decoder_i (
        .instr(instr),
        .decoded(decoded)
    );

    // one strobe per operation, already qualified by instr_valid, so no group acts on an idle word
    always_comb
    begin
        is_or_literal = 1'h0;
        is_or_file = 1'h0;
        is_copy_file = 1'h0;
        is_load_literal = 1'h0;
        is_store_file = 1'h0;
        is_store_special = 1'h0;
        if (instr_valid)
        begin
            case (decoded.op)
                OAME_OP_OR_LITERAL_INTO_ACCUMULATOR:
                begin
                    is_or_literal = 1'h1;
                end
                OAME_OP_OR_ACCUMULATOR_WITH_FILE:
                begin
                    is_or_file = 1'h1;
                end
                OAME_OP_COPY_FILE_TO_ACCUMULATOR:
                begin
                    is_copy_file = 1'h1;
                end
                OAME_OP_LOAD_LITERAL_TO_ACCUMULATOR:
                begin
                    is_load_literal = 1'h1;
                end
                OAME_OP_STORE_ACCUMULATOR_TO_FILE:
                begin
                    is_store_file = 1'h1;
                end
                OAME_OP_STORE_ACCUMULATOR_TO_SPECIAL:
                begin
                    is_store_special = 1'h1;
                end
                default:
                begin
                    // refused words leave every strobe low
                    is_or_literal = 1'h0;
                end
            endcase
        end
    end

    assign or_to_accumulator = is_or_literal || (is_or_file && decoded.dest == DEST_ACCUMULATOR);
    assign or_to_file = is_or_file && (decoded.dest == DEST_FILE);
    // operand is fetched outside and presented with the instruction
    assign or_operand = is_or_literal ? decoded.literal : file_rd_data;
    assign or_result = accumulator | or_operand;
    assign or_result_zero = (or_result == DATA_ZERO);

    // accumulator holds unless an OR aims at it or a move loads it; stores only read it
    always_comb
    begin
        next_accumulator = accumulator;
        if (or_to_accumulator)
        begin
            next_accumulator = or_result;
        end
        else if (is_copy_file)
        begin
            next_accumulator = file_rd_data;
        end
        else if (is_load_literal)
        begin
            next_accumulator = decoded.literal;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            accumulator <= ACCUMULATOR_RESET;
        end
        else
        begin
            accumulator <= next_accumulator;
        end
    end

    // zero flag follows the OR result whichever way it is routed; moves leave it alone
    always_comb
    begin
        next_zero_flag = zero_flag;
        if (is_or_literal || is_or_file)
        begin
            next_zero_flag = or_result_zero;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            zero_flag <= ZERO_FLAG_RESET;
        end
        else
        begin
            zero_flag <= next_zero_flag;
        end
    end

    // idle cycles drive zeros so the port never shows a stale address or data
    always_comb
    begin
        next_file_write = '0;
        if (or_to_file)
        begin
            next_file_write.en = 1'h1;
            next_file_write.addr = decoded.file_addr;
            next_file_write.data = or_result;
        end
        else if (is_store_file)
        begin
            next_file_write.en = 1'h1;
            next_file_write.addr = decoded.file_addr;
            next_file_write.data = accumulator;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            file_write <= '0;
        end
        else
        begin
            file_write <= next_file_write;
        end
    end

    always_comb
    begin
        next_special_write = '0;
        if (is_store_special)
        begin
            next_special_write.en = 1'h1;
            next_special_write.addr = decoded.special_addr;
            next_special_write.data = accumulator;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            special_write <= '0;
        end
        else
        begin
            special_write <= next_special_write;
        end
    end

    // pulses only for words of this group; refused encodings stay silent
    always_comb
    begin
        next_instr_done = is_or_literal || is_or_file || is_copy_file || is_load_literal
            || is_store_file || is_store_special;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            instr_done <= 1'h0;
        end
        else
        begin
            instr_done <= next_instr_done;
        end
    end

endmodule

/* dv/oame_exec_chk.sv */
`timescale 1ns/1ps
module oame_exec_chk
    import oame_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic [INSTR_WIDTH-1:0] instr,
    input wire logic [DATA_WIDTH-1:0] file_rd_data,
    input wire logic [DATA_WIDTH-1:0] accumulator,
    input wire logic zero_flag,
    input wire oame_file_write_type file_write,
    input wire oame_special_write_type special_write,
    input wire logic instr_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [5:0] op;
    logic [7:0] k;
    logic [6:0] fa;
    logic [5:0] ra;
    logic [7:0] res;
    // idle maps to an opcode outside this group
    assign op = instr_valid ? instr[13:8] : 6'h3f;
    assign k = instr[7:0];
    assign fa = instr[6:0];
    assign ra = instr[5:0];
    assign res = (op == 6'h1a) ? (accumulator | k) : (accumulator | file_rd_data);
    chk_or_lit_acc: assert property (op == 6'h1a |=> accumulator == $past(res) && instr_done)
        else $error("or literal result wrong");
    chk_or_file_acc: assert property (op == 6'h04 && !k[7] |=> accumulator == $past(res) && !file_write.en)
        else $error("or file to accumulator wrong");
    chk_or_file_wr: assert property (op == 6'h04 && k[7] |=>
        file_write == {1'b1, $past(fa), $past(res)} && $stable(accumulator)) else $error("or file write wrong");
    chk_zero_or: assert property (op == 6'h1a || op == 6'h04 |=> zero_flag == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    chk_copy_file: assert property (op == 6'h08 && !k[7] |=>
        accumulator == $past(file_rd_data) && $stable(zero_flag)) else $error("copy file wrong");
    chk_copy_refused: assert property (op == 6'h08 && k[7] |=> !instr_done && $stable(accumulator))
        else $error("refused copy acted");
    chk_load_lit: assert property (op == 6'h19 |=> accumulator == $past(k) && $stable(zero_flag))
        else $error("load literal wrong");
    chk_store_file: assert property (op == 6'h00 && k[7] |=>
        file_write == {1'b1, $past(fa), $past(accumulator)} && $stable(accumulator) && $stable(zero_flag))
        else $error("store file wrong");
    chk_store_spec: assert property (op == 6'h00 && k[7:6] == 2'h0 && ra != 6'h00 |=>
        special_write == {1'b1, $past(ra), $past(accumulator)} && $stable(zero_flag))
        else $error("store special wrong");
    chk_nop_idle: assert property (op == 6'h00 && k == 8'h00 |=> !instr_done && !special_write.en)
        else $error("no-operation acted");
endmodule

/* dv/oame_exec_tb_top.sv */
`timescale 1ns/1ps
module oame_exec_tb_top
    import oame_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr = 14'h0000;
    logic [7:0] file_rd_data = 8'h00;
    logic [7:0] accumulator;
    logic zero_flag;
    oame_file_write_type file_write;
    oame_special_write_type special_write;
    logic instr_done;
    int fail_count = 0;
    int num_checks = 0;
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    oame_exec oame_exec_i (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .file_rd_data(file_rd_data), .accumulator(accumulator), .zero_flag(zero_flag),
        .file_write(file_write), .special_write(special_write), .instr_done(instr_done));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // valid drops after one edge so a store is never taken twice
    task automatic step(input logic [13:0] w, input logic [7:0] rd);
        @(posedge core_clk);
        instr <= w;
        file_rd_data <= rd;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic t_or_literal;
        step(14'h199a, 8'h00);
        chk({instr_done, zero_flag, accumulator}, {2'b10, 8'h9a});
        step(14'h1a35, 8'h00);
        chk({instr_done, zero_flag, accumulator}, {2'b10, 8'hbf});
        step(14'h1900, 8'h00);
        step(14'h1a00, 8'h00);
        chk({instr_done, zero_flag, accumulator}, {2'b11, 8'h00});
        step(14'h1955, 8'h00);
        chk({zero_flag, accumulator}, {1'b1, 8'h55});
    endtask
    task automatic t_or_file;
        step(14'h1991, 8'h00);
        step(14'h047f, 8'h13);
        chk({file_write.en, zero_flag, accumulator}, {2'b00, 8'h93});
        step(14'h1980, 8'h00);
        step(14'h04c5, 8'h13);
        chk({file_write, accumulator}, {1'b1, 7'h45, 8'h93, 8'h80});
        step(14'h1900, 8'h00);
        step(14'h0480, 8'h00);
        chk({file_write, zero_flag}, {1'b1, 7'h00, 8'h00, 1'b1});
    endtask
    task automatic t_moves;
        step(14'h087f, 8'hc2);
        chk({zero_flag, accumulator}, {1'b1, 8'hc2});
        step(14'h0880, 8'h11);
        chk({instr_done, accumulator}, {1'b0, 8'hc2});
        step(14'h194f, 8'h00);
        step(14'h00ff, 8'h00);
        chk({file_write, accumulator}, {1'b1, 7'h7f, 8'h4f, 8'h4f});
        step(14'h003f, 8'h00);
        chk({special_write, file_write.en}, {1'b1, 6'h3f, 8'h4f, 1'b0});
        step(14'h0040, 8'h00);
        chk({instr_done, special_write.en}, 2'b00);
        step(14'h0000, 8'h00);
        chk({instr_done, special_write.en}, 2'b00);
    endtask
    // reset in mid-run must beat an instruction presented at the same edge
    task automatic t_mid_reset;
        step(14'h1900, 8'h00);
        step(14'h1a00, 8'h00);
        chk({instr_done, zero_flag, accumulator}, {2'b11, 8'h00});
        @(posedge core_clk);
        instr <= 14'h1955;
        instr_valid <= 1'b1;
        reset <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        reset <= 1'b0;
        #1;
        chk({instr_done, zero_flag, accumulator}, 10'h000);
        step(14'h1a3c, 8'h00);
        chk({instr_done, zero_flag, accumulator}, {2'b10, 8'h3c});
    endtask
    task automatic t_back2back;
        @(posedge core_clk);
        instr <= 14'h19f0;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr <= 14'h1a0f;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk({instr_done, zero_flag, accumulator}, {2'b10, 8'hff});
    endtask
    task tally_and_finish;
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({instr_done, zero_flag, accumulator}, 10'h000);
        t_or_literal;
        t_or_file;
        t_moves;
        t_back2back;
        t_mid_reset;
        tally_and_finish;
    end
    // whole run is under a hundred cycles
    initial
    begin
        #1600;
        fail_count++;
        tally_and_finish;
    end
endmodule
bind oame_exec oame_exec_chk oame_exec_chk_i (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid),
    .instr(instr), .file_rd_data(file_rd_data), .accumulator(accumulator), .zero_flag(zero_flag),
    .file_write(file_write), .special_write(special_write), .instr_done(instr_done));
